/* File: tb/rsi_properties.sv */
// Concurrent checks on the reset state initializer ports
`timescale 1ns/10ps
module rsi_properties import rsi_pkg::*; (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic i_SCAN_LOAD,
	input wire logic [2:0] i_REG_SEL,
	input wire logic [63:0] o_REG_RDATA,
	input wire logic o_APPLY,
	input wire logic [63:0] o_PC,
	input wire logic [63:0] o_NPC,
	input wire logic [RSI_TL_W-1:0] o_TRAP_LEVEL,
	input wire logic [RSI_TT_W-1:0] o_TRAP_TYPE,
	input wire logic [63:0] o_CYCLE_COUNT,
	input wire logic [63:0] o_SYSTEM_TICK_COUNTER_COUNT,
	input wire logic [63:0] o_VERSION
);
	logic por;
	logic external_reset;
	// Which vector the current apply went to
	assign por = o_APPLY && o_PC == RSI_VEC_BASE + RSI_OFF_POR;
	assign external_reset = o_APPLY && o_PC == RSI_VEC_BASE + RSI_OFF_XIR;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	a_next_pc_step: assert property (o_APPLY |-> o_NPC == o_PC + 64'h4)
		else $error("next pc is not vector plus four");
	a_por_type_level: assert property (por |->
		o_TRAP_TYPE == RSI_TT_POR && o_TRAP_LEVEL == RSI_MAX_TL)
		else $error("power-on type or level wrong");
	a_xir_type: assert property (external_reset |-> o_TRAP_TYPE == RSI_TT_XIR)
		else $error("external reset type wrong");
	a_sir_type: assert property (o_APPLY && o_PC == RSI_VEC_BASE + RSI_OFF_SIR
		|-> o_TRAP_TYPE == RSI_TT_SIR)
		else $error("software reset type wrong");
	// Level only saturates, it never wraps past the maximum
	a_level_step: assert property (o_APPLY && !por |-> o_TRAP_LEVEL ==
		($past(o_TRAP_LEVEL) == RSI_MAX_TL ? RSI_MAX_TL
		: $past(o_TRAP_LEVEL) + 3'h1))
		else $error("trap level step wrong");
	a_por_scan_first: assert property (por |-> $past(i_SCAN_LOAD, 2)
		|| $past(i_SCAN_LOAD, 3) || $past(i_SCAN_LOAD, 4))
		else $error("ran without status load");
	a_por_counters: assert property (por |-> o_CYCLE_COUNT[63]
		&& o_CYCLE_COUNT[62:0] < 63'h4 && o_SYSTEM_TICK_COUNTER_COUNT[63]
		&& o_SYSTEM_TICK_COUNTER_COUNT[62:0] < 63'h4)
		else $error("counters not restarted on power-on");
	a_xir_cycle: assert property (external_reset |-> o_CYCLE_COUNT[62:0] < 63'h4
		&& o_CYCLE_COUNT[63] == $past(o_CYCLE_COUNT[63]))
		else $error("cycle counter wrong on external reset");
	a_version_const: assert property (o_VERSION[10:8] == RSI_MAX_TL
		&& o_VERSION[4:0] == RSI_MAX_WIN && $stable(o_VERSION))
		else $error("version fields wrong");
	a_status_hidden: assert property (i_REG_SEL == 3'h7
		|-> o_REG_RDATA[63:1] == 63'h0)
		else $error("hidden status bits visible");
endmodule
bind rsi_top rsi_properties rsi_properties_i (.*);

/* File: tb/rsi_reset_facility.sv */
// Model of the external reset pin and scan-in test facility
`timescale 1ns/10ps
module rsi_reset_facility (
	input wire logic i_clk,
	output logic o_pin_n,
	output logic o_hard,
	output logic o_shift,
	output logic o_bit,
	output logic o_load
);
	// Idle scan data toggles so a stale bit never looks like data
	always @(posedge i_clk)
		if (!o_shift)
			o_bit <= #1 ~o_bit;
	initial begin
		{o_pin_n, o_hard, o_shift, o_bit, o_load} = 5'h0;
	end
	// Pin low, status scanned in bit 0 first, pin released, then load
	task automatic power_on(input logic hard, input logic [63:0] w);
		int i;
		@(posedge i_clk);
		#1 o_pin_n = 1'b0;
		o_hard = hard;
		for (i = 0; i < 64; i++) begin
			@(posedge i_clk);
			#1 o_shift = 1'b1;
			o_bit = w[i];
		end
		@(posedge i_clk);
		#1 o_shift = 1'b0;
		o_pin_n = 1'b1;
		repeat (4) @(posedge i_clk);
		#1 o_load = 1'b1;
		@(posedge i_clk);
		#1 o_load = 1'b0;
	endtask
endmodule

/* File: tb/rsi_top_bench.sv */
// Self-checking bench for the reset state initializer
`timescale 1ns/10ps
module rsi_top_bench import rsi_pkg::*;;
	logic I_CLK = 1'b0, I_RST = 1'b1, i_RESET_PIN_N, i_HARD_POR;
	logic i_SCAN_SHIFT, i_SCAN_BIT, i_SCAN_LOAD, i_REG_WE, o_RUN;
	logic i_XIR_REQ, i_SIR_REQ, i_WDT_TIMEOUT, i_TRAP_REQ, o_APPLY;
	logic o_ERROR_STATE, o_RED_STATE, got;
	logic [15:0] i_BUS_STRAPS;
	logic [RSI_TT_W-1:0] i_TRAP_TYPE, o_TRAP_TYPE;
	logic [63:0] i_CUR_PC, i_CUR_NPC, i_REG_WDATA, o_REG_RDATA, o_PC, o_NPC;
	logic [63:0] o_SAVED_PC, o_SAVED_NPC, o_CYCLE_COUNT, o_SYSTEM_TICK_COUNTER_COUNT;
	logic [63:0] o_VERSION, tid, bp;
	logic [7:0] i_CUR_CCR, i_CUR_ASI, i_REG_OFF;
	logic [11:0] i_CUR_PROCESSOR_STATE_WORD;
	logic [2:0] i_CUR_CWP, i_REG_SEL, i_STACK_SEL;
	logic [RSI_TL_W-1:0] o_TRAP_LEVEL;
	logic [30:0] o_SAVED_STATE;
	int miscompares = 0, num_checks = 0, exp_tl = 5;
	integer seed = 32'hce93;
	always #5 I_CLK = ~I_CLK;
	rsi_top rsi_top_i (.*);
	rsi_reset_facility rsi_reset_facility_i (.i_clk(I_CLK),
		.o_pin_n(i_RESET_PIN_N), .o_hard(i_HARD_POR), .o_shift(i_SCAN_SHIFT),
		.o_bit(i_SCAN_BIT), .o_load(i_SCAN_LOAD));
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [63:0] e, input logic [63:0] s);
		num_checks++;
		if (s !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, s);
			miscompares++;
		end
	endtask
	// Masked register read compared with the model value
	task rc(input [2:0] s, input [7:0] o, input [63:0] m, input [63:0] e);
		@(posedge I_CLK);
		#1 i_REG_SEL = s;
		i_REG_OFF = o;
		#1 chk("register", e, o_REG_RDATA & m);
	endtask
	task wr(input [2:0] s, input [7:0] o, input [63:0] d);
		@(posedge I_CLK);
		#1 {i_REG_WE, i_REG_SEL, i_REG_OFF, i_REG_WDATA} = {1'b1, s, o, d};
		@(posedge I_CLK);
		#1 i_REG_WE = 1'b0;
	endtask
	task pulse(input [3:0] m);
		@(posedge I_CLK);
		#1 {i_XIR_REQ, i_SIR_REQ, i_WDT_TIMEOUT, i_TRAP_REQ} = m;
		@(posedge I_CLK);
		#1 {i_XIR_REQ, i_SIR_REQ, i_WDT_TIMEOUT, i_TRAP_REQ} = 4'h0;
	endtask
	// Bounded wait for the apply pulse; a required one that never comes ends
	task wait_apply(input int n, input bit must);
		got = 1'b0;
		for (int i = 0; i < n && !got; i++) begin
			@(posedge I_CLK);
			#2 got = (o_APPLY === 1'b1);
		end
		if (must && !got) begin
			$display("ERROR apply expected 1 seen 0");
			miscompares++;
			stop_test;
		end
	endtask
	// Model of the vector, level and type after one event
	task ev_chk(input [63:0] off, input [8:0] tt);
		if (!got)
			wait_apply(60, 1);
		got = 1'b0;
		exp_tl = (off == RSI_OFF_POR) ? 5 : (exp_tl + 1 > 5 ? 5 : exp_tl + 1);
		chk("pc", RSI_VEC_BASE + off, o_PC);
		chk("npc", RSI_VEC_BASE + off + 64'h4, o_NPC);
		chk("level", exp_tl, o_TRAP_LEVEL);
		if (tt != 9'h0)
			chk("type", tt, o_TRAP_TYPE);
	endtask
	initial begin
		{i_XIR_REQ, i_SIR_REQ, i_WDT_TIMEOUT, i_TRAP_REQ, i_REG_WE} = 5'h0;
		got = 1'b0;
		{i_REG_SEL, i_REG_OFF, i_REG_WDATA, i_STACK_SEL} = {75'h0, 3'h5};
		i_TRAP_TYPE = 9'h041;
		i_BUS_STRAPS = $random(seed);
		i_CUR_PC = {$random(seed), $random(seed)} & ~64'h3;
		i_CUR_NPC = i_CUR_PC + 64'h4;
		{i_CUR_CCR, i_CUR_ASI, i_CUR_PROCESSOR_STATE_WORD, i_CUR_CWP} = $random(seed);
		tid = {$random(seed), $random(seed)};
		bp = {$random(seed), $random(seed)};
		repeat (16) @(posedge I_CLK);
		#1 I_RST = 1'b0;
		// Hard power-on, run mode without stop on error
		rsi_reset_facility_i.power_on(1'b1, {$random(seed), 32'h0});
		ev_chk(RSI_OFF_POR, RSI_TT_POR);
		chk("run", 1, o_RUN);
		rc(6, 8'h0, '1, 64'h8000000000000000);
		rc(6, 8'h8, '1, 64'h8000000000000000);
		rc(1, 8'h0, '1, 64'h0);
		rc(3, 8'h0, '1, 64'h0);
		rc(4, 8'h0, '1, 64'h0);
		rc(2, 8'h10, 64'h1, 64'h1);
		rc(2, 8'h0, '1, {48'h0, i_BUS_STRAPS});
		// Software writes, read-only and test-port-only places refused
		wr(4, 8'h0, tid);
		wr(3, 8'h0, bp);
		wr(2, 8'h10, 64'h0);
		wr(1, 8'h0, '1);
		wr(7, 8'h0, '1);
		wr(5, 8'h0, '1);
		wr(5, 8'h8, '1);
		rc(1, 8'h0, '1, 64'h0);
		rc(7, 8'h0, '1, 64'h0);
		pulse(4'h8);
		ev_chk(RSI_OFF_XIR, RSI_TT_XIR);
		chk("saved pc", i_CUR_PC, o_SAVED_PC);
		chk("saved npc", i_CUR_NPC, o_SAVED_NPC);
		chk("saved state", {i_CUR_CCR, i_CUR_ASI, i_CUR_PROCESSOR_STATE_WORD, i_CUR_CWP},
			o_SAVED_STATE);
		rc(4, 8'h0, '1, tid);
		rc(3, 8'h0, '1, bp);
		// Watchdog: a second time-out at the latest forces the reset
		pulse(4'h2);
		wait_apply(8, 0);
		if (!got)
			pulse(4'h2);
		ev_chk(RSI_OFF_WDR, RSI_TT_WDT);
		rc(2, 8'h10, 64'h1, 64'h1);
		// Software reset at the top level goes through the error state
		pulse(4'h4);
		ev_chk(RSI_OFF_WDR, RSI_TT_SIR);
		chk("red", 1, o_RED_STATE);
		// Soft power-on with stop on error selected
		rsi_reset_facility_i.power_on(1'b0, {$random(seed), 32'h1});
		ev_chk(RSI_OFF_POR, RSI_TT_POR);
		rc(4, 8'h0, '1, tid);
		rc(3, 8'h0, '1, 64'h0);
		rc(5, 8'h0, 64'h6, 64'h0);
		rc(5, 8'h8, 64'h0e000000, 64'h0);
		wr(7, 8'h0, 64'h0);
		rc(7, 8'h0, '1, 64'h1);
		pulse(4'h1);
		wait_apply(20, 0);
		chk("apply", 0, got);
		chk("error", 1, o_ERROR_STATE);
		stop_test;
	end
endmodule

/* File: verilog/rsi_pkg.sv */
// Package of constants and types for the reset state initializer
package rsi_pkg;
	// Reset and recovery event kinds
	typedef enum logic [2:0] {
		RSI_EV_NONE,
		RSI_EV_POR,
		RSI_EV_WDR,
		RSI_EV_XIR,
		RSI_EV_SIR,
		RSI_EV_RED
	} rsi_event_t;

	// Sequencer states
	typedef enum logic [1:0] {
		RSI_ST_SCAN,
		RSI_ST_RUN,
		RSI_ST_ERROR
	} rsi_state_t;

	localparam int RSI_TL_W = 3;
	localparam int RSI_TT_W = 9;
	localparam logic [RSI_TL_W-1:0] RSI_MAX_TL = 3'h5;
	localparam logic [4:0] RSI_MAX_WIN = 5'h07;
	localparam logic [RSI_TT_W-1:0] RSI_TT_POR = 9'h001;
	localparam logic [RSI_TT_W-1:0] RSI_TT_WDT = 9'h002;
	localparam logic [RSI_TT_W-1:0] RSI_TT_XIR = 9'h003;
	localparam logic [RSI_TT_W-1:0] RSI_TT_SIR = 9'h004;

	// Vector offsets from the reset vector base
	localparam logic [63:0] RSI_OFF_POR = 64'h20;
	localparam logic [63:0] RSI_OFF_WDR = 64'h40;
	localparam logic [63:0] RSI_OFF_XIR = 64'h60;
	localparam logic [63:0] RSI_OFF_SIR = 64'h80;
	localparam logic [63:0] RSI_OFF_RED = 64'ha0;
	localparam logic [63:0] RSI_NPC_STEP = 64'h4;
	localparam logic [63:0] RSI_VEC_BASE = 64'hfffffffff0000000;

	// Register offsets within their address spaces
	localparam logic [7:0] RSI_OFF_UNIT_CTRL = 8'h00;
	localparam logic [7:0] RSI_OFF_MEM_CTRL = 8'h08;
	localparam logic [7:0] RSI_OFF_ERR_CTRL = 8'h10;

	// Field positions
	localparam int RSI_NPT_BIT = 63;
	localparam int RSI_WEAK_ERROR_DETECT_BIT = 0;
	localparam int RSI_UT_BIT = 2;
	localparam int RSI_ST_BIT = 1;
	localparam int RSI_IM_BIT = 27;
	localparam int RSI_INTERVAL_ROUNDING_LSB = 25;
	localparam int RSI_OPERATING_STATUS_W = 64;
	localparam int RSI_OPERATING_STATUS_STOP_BIT = 0;

	// Reset values
	localparam logic [63:0] RSI_RST_ZERO = 64'h0;
	localparam logic [15:0] RSI_MANUF_ID = 16'h00a5; // Arbitrary value
	localparam logic [15:0] RSI_IMPL_ID = 16'h005a; // Arbitrary value

	// Version word: id fields, mask, max trap level, max window
	function automatic logic [63:0] rsi_version(input logic [7:0] mask);
		rsi_version = {RSI_MANUF_ID, RSI_IMPL_ID, mask, 8'h00,
			5'h00, RSI_MAX_TL, 3'h0, RSI_MAX_WIN};
	endfunction
endpackage

/* File: verilog/rsi_scan.sv */
// Serial scan-in shift register for the operating status word
`timescale 1ns/10ps
module rsi_scan import rsi_pkg::*; #(
	parameter int W = RSI_OPERATING_STATUS_W
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_shift,
	input wire logic i_bit,
	input wire logic i_load,
	output logic [W-1:0] o_word,
	output logic o_loaded
);
	logic [W-1:0] shift_r;

	// Shift register, LSB first into the top
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			shift_r <= '0;
		end else if (i_shift) begin
			shift_r <= {i_bit, shift_r[W-1:1]};
		end
	end

	// Word is transferred only on the load command
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_word <= '0;
			o_loaded <= 1'b0;
		end else begin
			o_loaded <= i_load;
			if (i_load) begin
				o_word <= shift_r;
			end
		end
	end
endmodule

/* File: verilog/rsi_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module rsi_sync #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_r <= '0;
			o_q <= '0;
		end else begin
			meta_r <= i_d;
			o_q <= meta_r;
		end
	end
endmodule

/* File: verilog/rsi_top.sv */
// Reset state initializer: architectural state on reset and recovery
// Function
// - Hard reset clears thread id and sets error control to 1; soft reset keeps thread id and sets only weak error detect
// - First watchdog in normal state, later in recovery
// - Trap type 1, 2/cause, 3, 4 by reset
// - Power-on sets max level, else min(level+1,max)
// - Non-power-on entries save state into trap stack
// - Cycle counter restarts on power-on and external
// - System tick restarts and bit set on power-on
// - Compare registers disabled and zeroed on power-on
// - Version reports level 5, window 7, read-only
// - Power-on clears user and supervisor trace enables
// - Power-on clears interval mode and rounding fields
// - Dispatch status cleared only by power-on reset
// - Power-on and watchdog set weak error detect
// - Thread id zero on hard, kept otherwise
// - Breakpoint register cleared only by power-on
// - Bus config loaded from straps on power-on
// - Execution waits for scan load of status
// - Status word changes only by test command
// - Status word mostly hidden from software
// - Vector is base plus per-type offset; next plus 4
// - Stop-on-error holds error state, else watchdog
`timescale 1ns/10ps
module rsi_top import rsi_pkg::*; #(
	parameter logic [7:0] MASK_REV = 8'h01
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic i_RESET_PIN_N,
	input wire logic i_HARD_POR,
	input wire logic i_SCAN_SHIFT,
	input wire logic i_SCAN_BIT,
	input wire logic i_SCAN_LOAD,
	input wire logic [15:0] i_BUS_STRAPS,
	input wire logic i_XIR_REQ,
	input wire logic i_SIR_REQ,
	input wire logic i_WDT_TIMEOUT,
	input wire logic i_TRAP_REQ,
	input wire logic [RSI_TT_W-1:0] i_TRAP_TYPE,
	input wire logic [63:0] i_CUR_PC,
	input wire logic [63:0] i_CUR_NPC,
	input wire logic [7:0] i_CUR_CCR,
	input wire logic [7:0] i_CUR_ASI,
	input wire logic [11:0] i_CUR_PROCESSOR_STATE_WORD,
	input wire logic [2:0] i_CUR_CWP,
	input wire logic i_REG_WE,
	input wire logic [2:0] i_REG_SEL,
	input wire logic [7:0] i_REG_OFF,
	input wire logic [63:0] i_REG_WDATA,
	input wire logic [2:0] i_STACK_SEL,
	output logic [63:0] o_REG_RDATA,
	output logic o_RUN,
	output logic o_ERROR_STATE,
	output logic o_RED_STATE,
	output logic o_APPLY,
	output logic [63:0] o_PC,
	output logic [63:0] o_NPC,
	output logic [RSI_TL_W-1:0] o_TRAP_LEVEL,
	output logic [RSI_TT_W-1:0] o_TRAP_TYPE,
	output logic [63:0] o_SAVED_PC,
	output logic [63:0] o_SAVED_NPC,
	output logic [30:0] o_SAVED_STATE,
	output logic [63:0] o_CYCLE_COUNT,
	output logic [63:0] o_SYSTEM_TICK_COUNTER_COUNT,
	output logic [63:0] o_VERSION
);
	// Register select codes for software access
	localparam logic [2:0] SEL_ASI45 = 3'h0;
	localparam logic [2:0] SEL_DISP = 3'h1;
	localparam logic [2:0] SEL_ERR = 3'h2;
	localparam logic [2:0] SEL_BKPT = 3'h3;
	localparam logic [2:0] SEL_EID = 3'h4;
	localparam logic [2:0] SEL_ASR = 3'h5;
	localparam logic [2:0] SEL_CMP = 3'h6;
	localparam logic [2:0] SEL_OPERATING_STATUS = 3'h7;

	logic pin_n_s, hard_s, xir_s, shift_s, sbit_s, load_s;
	logic [15:0] straps_s;
	logic [RSI_OPERATING_STATUS_W-1:0] operating_status;
	logic operating_status_loaded;
	rsi_state_t state_r;
	rsi_event_t ev;
	logic wdt_seen_r, in_red_r;
	logic [RSI_TL_W-1:0] tl_r;
	logic [RSI_TT_W-1:0] tt_r, err_tt_r;
	logic [63:0] spc_r [1:5];
	logic [63:0] snpc_r [1:5];
	logic [30:0] sst_r [1:5];
	logic [63:0] tick_r, system_tick_counter_r, tcmp_r, scmp_r;
	logic [63:0] unit_r, mem_r, disp_r, err_r, bkpt_r, eid_r;
	logic [63:0] pcr_r, gsr_r, bus_r;
	logic [RSI_TL_W-1:0] tl_new;
	logic [63:0] vec;

	// Pin and external controls cross into the core clock domain
	// Scan lines share the synchroniser so shift, bit and load stay aligned
	rsi_sync #(.W(22)) u_sync (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_d({i_RESET_PIN_N, i_HARD_POR, i_XIR_REQ, i_BUS_STRAPS,
			i_SCAN_SHIFT, i_SCAN_BIT, i_SCAN_LOAD}),
		.o_q({pin_n_s, hard_s, xir_s, straps_s, shift_s, sbit_s, load_s})
	);

	// Status word written only by scan or test command
	rsi_scan u_scan (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_shift(shift_s),
		.i_bit(sbit_s),
		.i_load(load_s),
		.o_word(operating_status),
		.o_loaded(operating_status_loaded)
	);

	function automatic logic [RSI_TL_W-1:0] next_tl(
		input logic [RSI_TL_W-1:0] t);
		next_tl = (t < RSI_MAX_TL) ? t + 3'h1 : RSI_MAX_TL;
	endfunction

	// Event priority: power-on, then error-state watchdog, then others
	always_comb begin
		ev = RSI_EV_NONE;
		if (state_r == RSI_ST_SCAN) begin
			if (pin_n_s && operating_status_loaded) begin
				ev = RSI_EV_POR;
			end
		end else if (state_r == RSI_ST_ERROR) begin
			if (!operating_status[RSI_OPERATING_STATUS_STOP_BIT]) begin
				ev = RSI_EV_WDR;
			end
		end else if (i_WDT_TIMEOUT && wdt_seen_r) begin
			ev = RSI_EV_WDR;
		end else if (xir_s) begin
			ev = RSI_EV_XIR;
		end else if (i_SIR_REQ && tl_r < RSI_MAX_TL) begin
			ev = RSI_EV_SIR;
		end else if (i_TRAP_REQ && in_red_r && tl_r < RSI_MAX_TL) begin
			ev = RSI_EV_RED;
		end
	end

	assign tl_new = next_tl(tl_r);

	// Vector selection by event
	always_comb begin
		case (ev)
			RSI_EV_POR: vec = RSI_VEC_BASE + RSI_OFF_POR;
			RSI_EV_WDR: vec = RSI_VEC_BASE + RSI_OFF_WDR;
			RSI_EV_XIR: vec = RSI_VEC_BASE + RSI_OFF_XIR;
			RSI_EV_SIR: vec = RSI_VEC_BASE + RSI_OFF_SIR;
			default: vec = RSI_VEC_BASE + RSI_OFF_RED;
		endcase
	end

	// Sequencer: scan hold, run, error state
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			state_r <= RSI_ST_SCAN;
			err_tt_r <= '0;
		end else if (!pin_n_s) begin
			state_r <= RSI_ST_SCAN;
		end else if (ev != RSI_EV_NONE) begin
			state_r <= RSI_ST_RUN;
		end else if (state_r == RSI_ST_RUN &&
			((i_SIR_REQ || i_TRAP_REQ || i_WDT_TIMEOUT) &&
			tl_r == RSI_MAX_TL)) begin
			// Max-level traps route through error state to a watchdog
			state_r <= RSI_ST_ERROR;
			err_tt_r <= i_SIR_REQ ? RSI_TT_SIR :
				(i_TRAP_REQ ? i_TRAP_TYPE : RSI_TT_WDT);
		end
	end

	// First timeout is an urgent error in normal state; later ones reset
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			wdt_seen_r <= 1'b0;
			in_red_r <= 1'b0;
		end else if (ev != RSI_EV_NONE) begin
			wdt_seen_r <= 1'b0;
			in_red_r <= 1'b1;
		end else if (i_WDT_TIMEOUT && state_r == RSI_ST_RUN) begin
			wdt_seen_r <= 1'b1;
		end
	end

	// Trap level, type, vectors: one cycle, before first fetch
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			tl_r <= RSI_MAX_TL;
			tt_r <= '0;
			o_PC <= '0;
			o_NPC <= '0;
			o_APPLY <= 1'b0;
		end else begin
			o_APPLY <= (ev != RSI_EV_NONE);
			if (ev != RSI_EV_NONE) begin
				o_PC <= vec;
				o_NPC <= vec + RSI_NPC_STEP;
				tl_r <= (ev == RSI_EV_POR) ? RSI_MAX_TL : tl_new;
				case (ev)
					RSI_EV_POR: tt_r <= RSI_TT_POR;
					RSI_EV_XIR: tt_r <= RSI_TT_XIR;
					RSI_EV_SIR: tt_r <= RSI_TT_SIR;
					RSI_EV_WDR: tt_r <= (state_r == RSI_ST_ERROR) ?
						err_tt_r : RSI_TT_WDT;
					default: tt_r <= i_TRAP_TYPE;
				endcase
			end
		end
	end

	// Trap stack entry at the new level; power-on leaves it alone
	always_ff @(posedge I_CLK) begin
		if (ev != RSI_EV_NONE && ev != RSI_EV_POR && tl_new != '0) begin
			spc_r[tl_new] <= i_CUR_PC;
			snpc_r[tl_new] <= i_CUR_NPC;
			sst_r[tl_new] <= {i_CUR_CCR, i_CUR_ASI, i_CUR_PROCESSOR_STATE_WORD,
				i_CUR_CWP};
		end
	end

	// Counters and compares; power-on restarts them whether hard or soft
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			tick_r <= RSI_RST_ZERO;
			system_tick_counter_r <= RSI_RST_ZERO;
			tcmp_r <= RSI_RST_ZERO;
			scmp_r <= RSI_RST_ZERO;
		end else if (ev == RSI_EV_POR) begin
			tick_r <= 64'h8000000000000000;
			system_tick_counter_r <= 64'h8000000000000000;
			tcmp_r <= 64'h8000000000000000;
			scmp_r <= 64'h8000000000000000;
		end else begin
			if (ev == RSI_EV_XIR) begin
				tick_r <= {tick_r[RSI_NPT_BIT], 63'h0};
			end else if (i_REG_WE && i_REG_SEL == SEL_ASR &&
				i_REG_OFF == 8'h04) begin
				tick_r <= i_REG_WDATA;
			end else begin
				tick_r <= {tick_r[63], 63'(tick_r[62:0] + 63'h1)};
			end
			system_tick_counter_r <= {system_tick_counter_r[63], 63'(system_tick_counter_r[62:0] + 63'h1)};
			if (i_REG_WE && i_REG_SEL == SEL_CMP) begin
				if (i_REG_OFF == 8'h00) begin
					tcmp_r <= i_REG_WDATA;
				end else begin
					scmp_r <= i_REG_WDATA;
				end
			end
		end
	end

	// Control registers and their power-on, watchdog updates
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			unit_r <= RSI_RST_ZERO;
			mem_r <= RSI_RST_ZERO;
			disp_r <= RSI_RST_ZERO;
			err_r <= RSI_RST_ZERO;
			bkpt_r <= RSI_RST_ZERO;
			eid_r <= RSI_RST_ZERO;
			pcr_r <= RSI_RST_ZERO;
			gsr_r <= RSI_RST_ZERO;
			bus_r <= RSI_RST_ZERO;
		end else if (ev == RSI_EV_POR) begin
			unit_r <= RSI_RST_ZERO;
			mem_r <= RSI_RST_ZERO;
			disp_r <= RSI_RST_ZERO;
			err_r[RSI_WEAK_ERROR_DETECT_BIT] <= 1'b1;
			bkpt_r <= RSI_RST_ZERO;
			if (hard_s) begin
				eid_r <= RSI_RST_ZERO;
				err_r <= 64'h1;
			end
			pcr_r[RSI_UT_BIT] <= 1'b0;
			pcr_r[RSI_ST_BIT] <= 1'b0;
			gsr_r[RSI_IM_BIT] <= 1'b0;
			gsr_r[RSI_INTERVAL_ROUNDING_LSB+1:RSI_INTERVAL_ROUNDING_LSB] <= 2'h0;
			bus_r <= {48'h0, straps_s};
		end else if (ev == RSI_EV_WDR) begin
			unit_r <= RSI_RST_ZERO;
			mem_r <= RSI_RST_ZERO;
			err_r[RSI_WEAK_ERROR_DETECT_BIT] <= 1'b1;
		end else if (i_REG_WE) begin
			case (i_REG_SEL)
				SEL_ASI45: begin
					if (i_REG_OFF == RSI_OFF_UNIT_CTRL) begin
						unit_r <= i_REG_WDATA;
					end else if (i_REG_OFF == RSI_OFF_MEM_CTRL) begin
						mem_r <= i_REG_WDATA;
					end
				end
				SEL_ERR: err_r <= i_REG_WDATA;
				SEL_BKPT: bkpt_r <= i_REG_WDATA;
				SEL_EID: eid_r <= i_REG_WDATA;
				SEL_ASR: begin
					if (i_REG_OFF == 8'h00) begin
						pcr_r <= i_REG_WDATA;
					end else if (i_REG_OFF == 8'h08) begin
						gsr_r <= i_REG_WDATA;
					end
				end
				default: ; // Status word and dispatch status ignore writes
			endcase
		end
	end

	// Read mux; version constant and status word mostly hidden
	always_comb begin
		case (i_REG_SEL)
			SEL_ASI45: o_REG_RDATA = (i_REG_OFF == RSI_OFF_MEM_CTRL) ?
				mem_r : unit_r;
			SEL_DISP: o_REG_RDATA = disp_r;
			SEL_ERR: o_REG_RDATA = (i_REG_OFF == RSI_OFF_ERR_CTRL) ?
				err_r : bus_r;
			SEL_BKPT: o_REG_RDATA = bkpt_r;
			SEL_EID: o_REG_RDATA = eid_r;
			SEL_ASR: o_REG_RDATA = (i_REG_OFF == 8'h00) ? pcr_r :
				((i_REG_OFF == 8'h08) ? gsr_r : tick_r);
			SEL_CMP: o_REG_RDATA = (i_REG_OFF == 8'h00) ? tcmp_r : scmp_r;
			default: o_REG_RDATA = {63'h0, operating_status[RSI_OPERATING_STATUS_STOP_BIT]};
		endcase
	end

	assign o_VERSION = rsi_version(MASK_REV);
	assign o_RUN = (state_r == RSI_ST_RUN);
	assign o_ERROR_STATE = (state_r == RSI_ST_ERROR);
	assign o_RED_STATE = in_red_r;
	assign o_TRAP_LEVEL = tl_r;
	assign o_TRAP_TYPE = tt_r;
	assign o_SAVED_PC = spc_r[i_STACK_SEL];
	assign o_SAVED_NPC = snpc_r[i_STACK_SEL];
	assign o_SAVED_STATE = sst_r[i_STACK_SEL];
	assign o_CYCLE_COUNT = tick_r;
	assign o_SYSTEM_TICK_COUNTER_COUNT = system_tick_counter_r;
endmodule
